//--- src/ame_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AME_PARAMS_SVH
`define AME_PARAMS_SVH
`define AME_OFS_STAT 8'h09
`define AME_OFS_DSTAT 8'h0A
`define AME_OFS_FIRST 8'h0B
`define AME_OFS_EN0 8'h16
`define AME_OFS_EN1 8'h17
`define AME_OFS_MAPA 8'h19
`define AME_OFS_MAPD 8'h1A
`define AME_OFS_MAPB 8'h1B
`define AME_OFS_PIN 8'h20
`define AME_OFS_LATCH 8'h21
`define AME_OFS_SDUR 8'h27
`define AME_OFS_STH 8'h28
`define AME_OFS_TTIM 8'h2A
`define AME_OFS_TTH 8'h2B
`define AME_B_SLOPE 2
`define AME_B_DTAP 4
`define AME_B_STAP 5
`define AME_B_NDATA 7
`define AME_B_DEN 4
`define AME_B_MAPD_A 0
`define AME_B_MAPD_B 7
`define AME_B_SIGN 3
`define AME_B_LVLA 0
`define AME_B_ODA 1
`define AME_B_LVLB 2
`define AME_B_ODB 3
`define AME_B_RSTINT 7
`define AME_B_SHOCK 6
`define AME_B_QUIET 7
`define AME_RST_BYTE 8'h00
`define AME_STH_SHIFT 2
`define AME_TTH_SHIFT 6
`define AME_CLK_NS 25
`define AME_TICK_US 250
`define AME_TICK_CYC (`AME_TICK_US * 1000 / `AME_CLK_NS)
`define AME_ND_LOW_US 50
`define AME_ND_LOW_CYC ((`AME_ND_LOW_US * 1000 + `AME_CLK_NS - 1) / `AME_CLK_NS)
`define AME_TAP_CLR_US 12500
`define AME_TAP_CLR_TK (`AME_TAP_CLR_US / `AME_TICK_US)
`define AME_SHOCK0_TK (50000 / `AME_TICK_US)
`define AME_SHOCK1_TK (75000 / `AME_TICK_US)
`define AME_QUIET0_TK (30000 / `AME_TICK_US)
`define AME_QUIET1_TK (20000 / `AME_TICK_US)
`endif

//--- src/ame_pkg.sv
// Types used by the tap interrupt engine
package ame_pkg;
  typedef enum logic [2:0] {
    AME_IDLE = 3'b000,
    AME_SHOCK = 3'b001,
    AME_QUIET = 3'b010,
    AME_WAIT2 = 3'b011,
    AME_SHOCK2 = 3'b100,
    AME_QUIET2 = 3'b101
  } ame_tap_st_t;
endpackage

//--- src/ame_top.sv
// Accelerometer new-data, motion and tap interrupt engines with pin routing
`timescale 1ns/1ps
`include "ame_params.svh"
module ame_top import ame_pkg::*; #(
  parameter int TICK_CYC = `AME_TICK_CYC,
  parameter int DW = 12
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic sample_valid_in,
  input wire logic acq_start_in,
  input wire logic signed [DW-1:0] acc_x_in,
  input wire logic signed [DW-1:0] acc_y_in,
  input wire logic signed [DW-1:0] acc_z_in,
  output logic irq_pin_a_out,
  output logic irq_pin_a_oe_out,
  output logic irq_pin_b_out,
  output logic irq_pin_b_oe_out
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] en0_ff, en1_ff, map_a_ff, map_d_ff, map_b_ff, pin_ff;
  logic [7:0] latch_ff, sdur_ff, motion_threshold_ff, ttim_ff, tth_ff;
  logic wr_rst_int;
  assign wr_rst_int = wr_in && addr_in == `AME_OFS_LATCH &&
                      wdata_in[`AME_B_RSTINT];

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      en0_ff <= `AME_RST_BYTE;
      en1_ff <= `AME_RST_BYTE;
      map_a_ff <= `AME_RST_BYTE;
      map_d_ff <= `AME_RST_BYTE;
      map_b_ff <= `AME_RST_BYTE;
      pin_ff <= `AME_RST_BYTE;
      latch_ff <= `AME_RST_BYTE;
      sdur_ff <= `AME_RST_BYTE;
      motion_threshold_ff <= `AME_RST_BYTE;
      ttim_ff <= `AME_RST_BYTE;
      tth_ff <= `AME_RST_BYTE;
    end else if (wr_in) begin
      case (addr_in)
        `AME_OFS_EN0: en0_ff <= wdata_in;
        `AME_OFS_EN1: en1_ff <= wdata_in;
        `AME_OFS_MAPA: map_a_ff <= wdata_in;
        `AME_OFS_MAPD: map_d_ff <= wdata_in;
        `AME_OFS_MAPB: map_b_ff <= wdata_in;
        `AME_OFS_PIN: pin_ff <= wdata_in;
        `AME_OFS_LATCH: latch_ff <= {4'h0, wdata_in[3:0]};
        `AME_OFS_SDUR: sdur_ff <= {6'h00, wdata_in[1:0]};
        `AME_OFS_STH: motion_threshold_ff <= wdata_in;
        `AME_OFS_TTIM: ttim_ff <= wdata_in;
        `AME_OFS_TTH: tth_ff <= {3'h0, wdata_in[4:0]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared time base; every window except the new-data low time counts these ticks
  logic [15:0] pre_ff;
  logic tick;
  assign tick = pre_ff == 16'(TICK_CYC - 1);
  always_ff @(posedge mclk_in) begin
    if (reset_in || tick) pre_ff <= 16'h0000;
    else pre_ff <= pre_ff + 16'h0001;
  end

  // Hold time of temporary mode in ticks; zero for non-latched or latched
  function automatic logic [15:0] hold_tk(input logic [3:0] m);
    case (m)
      4'h1: hold_tk = 16'd1000;
      4'h2: hold_tk = 16'd2000;
      4'h3: hold_tk = 16'd4000;
      4'h4: hold_tk = 16'd8000;
      4'h5: hold_tk = 16'd16000;
      4'h6: hold_tk = 16'd32000;
      4'h9: hold_tk = 16'd1;
      4'hA: hold_tk = 16'd2;
      4'hB: hold_tk = 16'd4;
      4'hC: hold_tk = 16'd50;
      4'hD: hold_tk = 16'd100;
      4'hE: hold_tk = 16'd200;
      default: hold_tk = 16'h0000;
    endcase
  endfunction
  logic mode_latched, mode_temp;
  assign mode_latched = latch_ff[2:0] == 3'b111;
  assign mode_temp = hold_tk(latch_ff[3:0]) != 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Samples arrive at twice the filter bandwidth, so the previous
  // sample is exactly the slope partner.
  logic signed [DW-1:0] acc [3];
  assign acc[0] = acc_x_in;
  assign acc[1] = acc_y_in;
  assign acc[2] = acc_z_in;
  logic [2:0] exc, blw, neg, tap_ax;
  logic [2:0] nmax;
  assign nmax = {1'b0, sdur_ff[1:0]} + 3'd1;

  for (genvar i = 0; i < 3; i++) begin : g_ax
    logic signed [DW-1:0] prev_ff;
    logic signed [DW:0] diff;
    logic [DW:0] mag;
    logic [2:0] hi_ff, lo_ff;
    logic hit;
    assign diff = (DW+1)'(acc[i]) - (DW+1)'(prev_ff);
    assign mag = diff[DW] ? (DW+1)'(-diff) : diff;
    assign hit = mag > (DW+1)'({motion_threshold_ff,
                                 `AME_STH_SHIFT'(0)});
    assign tap_ax[i] = mag > (DW+1)'({tth_ff[4:0],
                                       `AME_TTH_SHIFT'(0)});
    assign neg[i] = diff[DW];
    // The current slope counts too, so the Nth slope acts at once
    assign exc[i] = hit && hi_ff >= nmax - 3'd1;
    assign blw[i] = !hit && lo_ff >= nmax - 3'd1;
    always_ff @(posedge mclk_in) begin
      if (reset_in) begin
        prev_ff <= '0;
        hi_ff <= 3'd0;
        lo_ff <= 3'd0;
      end else if (sample_valid_in) begin
        prev_ff <= acc[i];
        hi_ff <= hit ? (hi_ff == 3'd4 ? hi_ff : hi_ff + 3'd1) : 3'd0;
        lo_ff <= hit ? 3'd0 : (lo_ff == 3'd4 ? lo_ff : lo_ff + 3'd1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] slope_en;
  logic slope_set, slope_clr, slope_st_ff;
  logic [2:0] first_ff;
  logic sign_ff;
  logic [15:0] s_hold_ff;
  assign slope_en = en0_ff[2:0];
  assign slope_set = sample_valid_in && |(exc & slope_en);
  assign slope_clr = sample_valid_in && &(blw | ~slope_en);

  always_ff @(posedge mclk_in) begin
    if (reset_in || slope_en == 3'b000) begin
      slope_st_ff <= 1'b0;
    end else if (slope_set && (!slope_st_ff || !mode_latched)) begin
      slope_st_ff <= 1'b1;
    end else if (mode_latched ? wr_rst_int :
                 mode_temp ? (s_hold_ff == 16'h0001 && tick) :
                 slope_clr) begin
      slope_st_ff <= 1'b0;
    end
  end

  // Hold counter for temporary mode, loaded only when the status rises
  always_ff @(posedge mclk_in) begin
    if (reset_in) s_hold_ff <= 16'h0000;
    else if (slope_set && !slope_st_ff) s_hold_ff <= hold_tk(latch_ff[3:0]);
    else if (tick && s_hold_ff != 16'h0000) s_hold_ff <= s_hold_ff - 16'h1;
  end

  // First axis takes the lowest enabled exceeding axis so exactly one flag is set
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      first_ff <= 3'b000;
      sign_ff <= 1'b0;
    end else if (slope_set && !slope_st_ff) begin
      first_ff <= (exc[0] && slope_en[0]) ? 3'b001 :
                  (exc[1] && slope_en[1]) ? 3'b010 : 3'b100;
      sign_ff <= (exc[0] && slope_en[0]) ? neg[0] :
                 (exc[1] && slope_en[1]) ? neg[1] : neg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic nd_en, nd_st_ff, nd_pend_ff;
  logic [11:0] nd_low_ff;
  assign nd_en = en1_ff[`AME_B_DEN];
  // Mode field is never consulted: new data is always non-latched
  always_ff @(posedge mclk_in) begin
    if (reset_in || !nd_en) begin
      nd_st_ff <= 1'b0;
      nd_pend_ff <= 1'b0;
      nd_low_ff <= 12'h000;
    end else begin
      if ((sample_valid_in || nd_pend_ff) && nd_low_ff == 12'h000) begin
        nd_st_ff <= 1'b1;
        nd_pend_ff <= 1'b0;
      end else if (sample_valid_in) begin
        nd_pend_ff <= 1'b1;
      end else if (acq_start_in && nd_st_ff) begin
        nd_st_ff <= 1'b0;
        nd_low_ff <= 12'(`AME_ND_LOW_CYC);
      end
      if (nd_low_ff != 12'h000) nd_low_ff <= nd_low_ff - 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  ame_tap_st_t tap_ff;
  logic [11:0] tcnt_ff;
  logic tev, tdone, s_tap_en, d_tap_en, s_tap_ff, d_tap_ff;
  logic s_fire, d_fire;
  logic [5:0] s_clr_ff, d_clr_ff;
  logic [11:0] shock_tk, quiet_tk, dur_tk;
  assign s_tap_en = en0_ff[`AME_B_STAP];
  assign d_tap_en = en0_ff[`AME_B_DTAP];
  assign tev = sample_valid_in && |tap_ax;
  assign tdone = tick && tcnt_ff <= 12'h001;
  assign shock_tk = ttim_ff[`AME_B_SHOCK] ? 12'(`AME_SHOCK1_TK) :
                                             12'(`AME_SHOCK0_TK);
  assign quiet_tk = ttim_ff[`AME_B_QUIET] ? 12'(`AME_QUIET1_TK) :
                                             12'(`AME_QUIET0_TK);
  always_comb begin
    case (ttim_ff[2:0])
      3'd0: dur_tk = 12'd200;
      3'd1: dur_tk = 12'd400;
      3'd2: dur_tk = 12'd600;
      3'd3: dur_tk = 12'd800;
      3'd4: dur_tk = 12'd1000;
      3'd5: dur_tk = 12'd1500;
      3'd6: dur_tk = 12'd2000;
      default: dur_tk = 12'd2800;
    endcase
  end
  assign s_fire = tap_ff == AME_QUIET && tdone && !tev;
  assign d_fire = tap_ff == AME_QUIET2 && tdone && !tev;

  always_ff @(posedge mclk_in) begin
    if (reset_in || !(s_tap_en || d_tap_en)) begin
      tap_ff <= AME_IDLE;
      tcnt_ff <= 12'h000;
    end else begin
      if (tick && tcnt_ff != 12'h000) tcnt_ff <= tcnt_ff - 12'h001;
      case (tap_ff)
        AME_IDLE: if (tev) begin
          tap_ff <= AME_SHOCK;
          tcnt_ff <= shock_tk;
        end
        AME_SHOCK, AME_SHOCK2: if (tdone) begin
          tap_ff <= tap_ff == AME_SHOCK ? AME_QUIET : AME_QUIET2;
          tcnt_ff <= quiet_tk;
        end
        AME_QUIET: if (tev) begin
          tap_ff <= AME_IDLE;
        end else if (tdone) begin
          tap_ff <= d_tap_en ? AME_WAIT2 : AME_IDLE;
          tcnt_ff <= dur_tk;
        end
        AME_WAIT2: if (tev) begin
          tap_ff <= AME_SHOCK2;
          tcnt_ff <= shock_tk;
        end else if (tdone) begin
          tap_ff <= AME_IDLE;
        end
        AME_QUIET2: if (tev || tdone) begin
          tap_ff <= AME_IDLE;
        end
        default: tap_ff <= AME_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in || !s_tap_en) begin
      s_tap_ff <= 1'b0;
      s_clr_ff <= 6'h00;
    end else if (s_fire) begin
      s_tap_ff <= 1'b1;
      s_clr_ff <= 6'(`AME_TAP_CLR_TK);
    end else if ((tick && s_clr_ff == 6'h01) ||
                 (mode_latched && wr_rst_int)) begin
      s_tap_ff <= 1'b0;
      s_clr_ff <= 6'h00;
    end else if (tick && s_clr_ff != 6'h00) begin
      s_clr_ff <= s_clr_ff - 6'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in || !d_tap_en) begin
      d_tap_ff <= 1'b0;
      d_clr_ff <= 6'h00;
    end else if (d_fire) begin
      d_tap_ff <= 1'b1;
      d_clr_ff <= 6'(`AME_TAP_CLR_TK);
    end else if ((tick && d_clr_ff == 6'h01) ||
                 (mode_latched && wr_rst_int)) begin
      d_tap_ff <= 1'b0;
      d_clr_ff <= 6'h00;
    end else if (tick && d_clr_ff != 6'h00) begin
      d_clr_ff <= d_clr_ff - 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain releases the pin when inactive; the pull sets the level
  logic [7:0] stat;
  logic act_a, act_b, lv_a, lv_b;
  assign stat = 8'((slope_st_ff << `AME_B_SLOPE) |
                   (d_tap_ff << `AME_B_DTAP) |
                   (s_tap_ff << `AME_B_STAP));
  assign act_a = |(map_a_ff & stat) ||
                 (map_d_ff[`AME_B_MAPD_A] && nd_st_ff);
  assign act_b = |(map_b_ff & stat) ||
                 (map_d_ff[`AME_B_MAPD_B] && nd_st_ff);
  assign lv_a = pin_ff[`AME_B_LVLA];
  assign lv_b = pin_ff[`AME_B_LVLB];
  assign irq_pin_a_out = lv_a ? act_a : !act_a;
  assign irq_pin_b_out = lv_b ? act_b : !act_b;
  assign irq_pin_a_oe_out = !pin_ff[`AME_B_ODA] || act_a;
  assign irq_pin_b_oe_out = !pin_ff[`AME_B_ODB] || act_b;

  always_ff @(posedge mclk_in) begin
    if (reset_in || !rd_in) begin
      rdata_out <= 8'h00;
    end else begin
      case (addr_in)
        `AME_OFS_STAT: rdata_out <= stat;
        `AME_OFS_DSTAT: rdata_out <= 8'(nd_st_ff << `AME_B_NDATA);
        `AME_OFS_FIRST: rdata_out <= {4'h0, sign_ff, first_ff};
        `AME_OFS_EN0: rdata_out <= en0_ff;
        `AME_OFS_EN1: rdata_out <= en1_ff;
        `AME_OFS_MAPA: rdata_out <= map_a_ff;
        `AME_OFS_MAPD: rdata_out <= map_d_ff;
        `AME_OFS_MAPB: rdata_out <= map_b_ff;
        `AME_OFS_PIN: rdata_out <= pin_ff;
        `AME_OFS_LATCH: rdata_out <= latch_ff;
        `AME_OFS_SDUR: rdata_out <= sdur_ff;
        `AME_OFS_STH: rdata_out <= motion_threshold_ff;
        `AME_OFS_TTIM: rdata_out <= ttim_ff;
        `AME_OFS_TTH: rdata_out <= tth_ff;
        default: rdata_out <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_pin_a_route;
    @(posedge mclk_in) disable iff (reset_in)
    map_a_ff[`AME_B_SLOPE] && slope_st_ff |-> irq_pin_a_out == lv_a;
  endproperty
  a_pin_a_route: assert property (p_pin_a_route)
    else $error("pin A not active with routed motion");
  property p_pin_b_lvl;
    @(posedge mclk_in) disable iff (reset_in)
    !act_b && !pin_ff[`AME_B_ODB] |-> irq_pin_b_out == !lv_b;
  endproperty
  a_pin_b_lvl: assert property (p_pin_b_lvl)
    else $error("pin B idle level wrong");
  property p_od_release;
    @(posedge mclk_in) disable iff (reset_in)
    pin_ff[`AME_B_ODA] && stat == 8'h00 && !nd_st_ff |-> !irq_pin_a_oe_out;
  endproperty
  a_od_release: assert property (p_od_release)
    else $error("open-drain pin A driven while idle");
  property p_nd_low;
    @(posedge mclk_in) disable iff (reset_in)
    $fell(nd_st_ff) && nd_en |-> nd_low_ff == 12'(`AME_ND_LOW_CYC);
  endproperty
  a_nd_low: assert property (p_nd_low)
    else $error("new data low time not started");
  property p_nd_hold;
    @(posedge mclk_in) disable iff (reset_in)
    nd_low_ff != 12'h000 |=> !nd_st_ff;
  endproperty
  a_nd_hold: assert property (p_nd_hold)
    else $error("new data status rose too soon");
  property p_first_onehot;
    @(posedge mclk_in) disable iff (reset_in)
    $rose(slope_st_ff) |-> $onehot(first_ff);
  endproperty
  a_first_onehot: assert property (p_first_onehot)
    else $error("first-axis flags not one-hot");
  property p_slope_cause;
    @(posedge mclk_in) disable iff (reset_in)
    $rose(slope_st_ff) |-> $past(sample_valid_in) && $past(|exc);
  endproperty
  a_slope_cause: assert property (p_slope_cause)
    else $error("motion status rose without consecutive exceed");
  property p_tap_disable;
    @(posedge mclk_in) disable iff (reset_in)
    !s_tap_en |=> !s_tap_ff;
  endproperty
  a_tap_disable: assert property (p_tap_disable)
    else $error("single tap status kept while disabled");
  property p_tap_hold;
    @(posedge mclk_in) disable iff (reset_in)
    $rose(d_tap_ff) |-> d_clr_ff == 6'(`AME_TAP_CLR_TK) && $past(d_fire);
  endproperty
  a_tap_hold: assert property (p_tap_hold)
    else $error("double tap not timed for auto clear");
endmodule

//--- test/ame_host_model.sv
// Host-side model that resolves the interrupt wires and reports activity
`timescale 1ns/1ps
module ame_host_model (
  input wire logic pin_a_in,
  input wire logic pin_a_oe_in,
  input wire logic lvl_a_in,
  input wire logic pin_b_in,
  input wire logic pin_b_oe_in,
  input wire logic lvl_b_in,
  output logic act_a_out,
  output logic act_b_out
);
  logic line_a;
  logic line_b;
  // A released line sits at the inactive level through its resistor
  always_comb begin
    line_a = pin_a_oe_in ? pin_a_in : ~lvl_a_in;
    line_b = pin_b_oe_in ? pin_b_in : ~lvl_b_in;
    act_a_out = (line_a == lvl_a_in);
    act_b_out = (line_b == lvl_b_in);
  end
endmodule

//--- test/ame_top_tb.sv
// Self-checking bench for the interrupt engines and pin routing
`timescale 1ns/1ps
`include "ame_params.svh"
module ame_top_tb;
  localparam int TK = 4;
  localparam int SQ = (`AME_SHOCK0_TK + `AME_QUIET0_TK) * TK;
  localparam int CLR = `AME_TAP_CLR_TK * TK;
  localparam int ND = `AME_ND_LOW_CYC;
  localparam int LIMIT = 20000;
  localparam logic [23:0] ROWS [14] = '{
    24'h09FF00, 24'h0AFF00, 24'h0BFF00, 24'h163737, 24'h171010,
    24'h193434, 24'h1A8181, 24'h1B3434, 24'h270303, 24'h28A5A5,
    24'h2AC7C7, 24'h2B1F1F, 24'h218F0F, 24'h3F5A00};
  logic mclk_in, reset_in, wr_in, rd_in, sample_valid_in, acq_start_in;
  logic [7:0] addr_in, wdata_in, rdata_out, pin_cfg;
  logic [11:0] acc_x_in, acc_y_in, acc_z_in;
  logic irq_pin_a_out, irq_pin_a_oe_out, irq_pin_b_out, irq_pin_b_oe_out;
  logic act_a, act_b;
  logic [7:0] pins_now;
  int errors, total_checks, cycles;

  assign pins_now = {1'b0, act_b, irq_pin_b_oe_out, irq_pin_b_out,
                     1'b0, act_a, irq_pin_a_oe_out, irq_pin_a_out};

  ame_top #(.TICK_CYC(TK), .DW(12)) dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sample_valid_in(sample_valid_in),
    .acq_start_in(acq_start_in), .acc_x_in(acc_x_in),
    .acc_y_in(acc_y_in), .acc_z_in(acc_z_in),
    .irq_pin_a_out(irq_pin_a_out), .irq_pin_a_oe_out(irq_pin_a_oe_out),
    .irq_pin_b_out(irq_pin_b_out), .irq_pin_b_oe_out(irq_pin_b_oe_out));

  ame_host_model host (
    .pin_a_in(irq_pin_a_out), .pin_a_oe_in(irq_pin_a_oe_out),
    .lvl_a_in(pin_cfg[0]), .pin_b_in(irq_pin_b_out),
    .pin_b_oe_in(irq_pin_b_oe_out), .lvl_b_in(pin_cfg[2]),
    .act_a_out(act_a), .act_b_out(act_b));

  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short here and counted as a mismatch
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      $display("CHECK FAILED at %0t: timeout %h %h", $time, cycles, LIMIT);
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    if (a == 8'h20) pin_cfg = d;
  endtask

  // Read data stand only in the cycle after the read strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
                      input logic [7:0] m = 8'hFF);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    chk(rdata_out & m, exp);
  endtask

  task automatic smp(input int x, input int y, input int z);
    @(posedge mclk_in);
    sample_valid_in <= 1'b1;
    acc_x_in <= x[11:0];
    acc_y_in <= y[11:0];
    acc_z_in <= z[11:0];
    @(posedge mclk_in);
    sample_valid_in <= 1'b0;
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  function automatic logic [2:0] pin_exp(input logic lvl, input logic od,
                                         input logic act);
    return {act, ~od | act, lvl ? act : ~act};
  endfunction

  // Every level and driver combination on both pins
  task automatic pin_loop(input logic act);
    for (int i = 0; i < 16; i++) begin
      wr(8'h20, 8'(i));
      @(negedge mclk_in);
      chk(pins_now, {1'b0, pin_exp(pin_cfg[2], pin_cfg[3], act), 1'b0,
                     pin_exp(pin_cfg[0], pin_cfg[1], act)});
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge mclk_in);
    reset_in <= 1'b1;
    wait_c(n);
    reset_in <= 1'b0;
    pin_cfg = 8'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    sample_valid_in = 1'b0;
    acq_start_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    acc_x_in = 12'h000;
    acc_y_in = 12'h000;
    acc_z_in = 12'h000;
    pin_cfg = 8'h00;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    do_reset(16);
    for (int r = 0; r < 14; r++) begin
      wr(ROWS[r][23:16], ROWS[r][15:8]);
      rchk(ROWS[r][23:16], ROWS[r][7:0]);
    end
    $display("test register table done");

    do_reset(2);
    @(negedge mclk_in);
    chk(pins_now, 8'h33);
    rchk(8'h28, 8'h00);
    pin_loop(1'b0);
    $display("test reset and idle pins done");

    wr(8'h17, 8'h10);
    wr(8'h1A, 8'h81);
    wr(8'h21, 8'h07);
    smp(0, 0, 0);
    rchk(8'h0A, 8'h80);
    pin_loop(1'b1);
    @(posedge mclk_in);
    acq_start_in <= 1'b1;
    @(posedge mclk_in);
    acq_start_in <= 1'b0;
    rchk(8'h0A, 8'h00);
    smp(0, 0, 0);
    wait_c(ND - 200);
    rchk(8'h0A, 8'h00);
    wait_c(300);
    rchk(8'h0A, 8'h80);
    wr(8'h17, 8'h00);
    rchk(8'h0A, 8'h00);
    wr(8'h21, 8'h00);
    $display("test new data done");

    wr(8'h16, 8'h07);
    wr(8'h28, 8'h01);
    wr(8'h27, 8'h01);
    wr(8'h19, 8'h04);
    wr(8'h20, 8'h01);
    smp(0, 0, 0);
    smp(0, -10, 0);
    rchk(8'h09, 8'h00);
    smp(0, -20, 0);
    rchk(8'h09, 8'h04);
    rchk(8'h0B, 8'h0A);
    @(negedge mclk_in);
    chk(pins_now & 8'h07, 8'h07);
    // A slope equal to the threshold does not count as exceeding it
    smp(0, -24, 0);
    rchk(8'h09, 8'h04);
    smp(0, -28, 0);
    rchk(8'h09, 8'h00);
    wr(8'h21, 8'h07);
    smp(10, -28, 0);
    smp(20, -28, 0);
    rchk(8'h0B, 8'h01);
    smp(20, -28, 0);
    smp(20, -28, 0);
    rchk(8'h09, 8'h04);
    wr(8'h21, 8'h87);
    rchk(8'h09, 8'h00);
    smp(30, -28, 0);
    smp(40, -28, 0);
    rchk(8'h09, 8'h04);
    wr(8'h16, 8'h00);
    rchk(8'h09, 8'h00);
    // A 12.5 ms temporary hold outlasts the quiet samples that follow
    wr(8'h21, 8'h0C);
    wr(8'h16, 8'h01);
    smp(50, -28, 0);
    smp(50, -28, 0);
    smp(50, -28, 0);
    rchk(8'h09, 8'h04);
    wait_c(CLR);
    rchk(8'h09, 8'h00);
    wr(8'h16, 8'h00);
    wr(8'h21, 8'h00);
    $display("test motion done");

    // Both taps are left unmapped while only status is watched
    wr(8'h19, 8'h00);
    wr(8'h16, 8'h30);
    wr(8'h2B, 8'h01);
    wr(8'h2A, 8'h00);
    smp(0, 0, 0);
    smp(0, 0, 100);
    wait_c(300);
    smp(0, 0, 0);
    wait_c(SQ - 340);
    rchk(8'h09, 8'h00, 8'h20);
    wait_c(80);
    rchk(8'h09, 8'h20, 8'h20);
    wait_c(CLR);
    rchk(8'h09, 8'h00, 8'h20);
    smp(0, 0, 100);
    wait_c(SQ + 60);
    rchk(8'h09, 8'h10, 8'h10);
    wait_c(CLR);
    rchk(8'h09, 8'h00, 8'h10);
    wait_c(1000);
    smp(0, 0, 0);
    wait_c(SQ - 400);
    smp(0, 0, 100);
    wait_c(440);
    rchk(8'h09, 8'h00, 8'h20);
    $display("test tap done");
    give_verdict();
  end
endmodule
